// ==== dv/ext_config_bank_bench.sv ====
// self-checking bench for the extended configuration bank
`timescale 1ns/100ps
`default_nettype none
module ext_config_bank_bench;
  import ext_config_pkg::*;
  logic clk = 1'b0, link_clk = 1'b1, reset = 1'b1, media_start = 1'b0, media_done = 1'b0;
  logic hw_reset_pin = 1'b0;
  op_kind_t media_kind = OP_NONE;
  op_kind_t op_kind;
  link_req_t cmd;
  logic cmd_valid, cmd_ready, rd_valid, rd_last, link_fast, link_busy, busy, cache_enable, maint_enable;
  logic [7:0] rd_data;
  int fail_count = 0, cmp_count = 0;
  //==========================================================================
  // clocks; the 8 MHz link stays below the slow-timing ceiling
  always #2 clk = ~clk;
  always #62.5 link_clk = ~link_clk;
  // init-after-setup, notice and aligned-trim bounds keep their defaults; those ops are ended by the media side
  ext_config_bank #(.INIT_CYC(32'd60), .PART_CYC(32'd70), .TRIM_CYC(32'd80),
    .STRIM1_CYC(32'd100), .STRIM2_CYC(32'd110)) dut (.clk, .reset, .link_clk, .cmd_valid, .cmd, .cmd_ready,
    .rd_valid, .rd_last, .rd_data, .link_fast, .link_busy, .hw_reset_pin, .media_start, .media_kind,
    .media_done, .op_kind, .busy, .cache_enable, .maint_enable);
  link_host_model host (.link_clk, .cmd, .cmd_valid, .cmd_ready, .rd_valid, .rd_last, .rd_data);
  //==========================================================================
  // compare with optional slack for counted spans
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    cmp_count++;
    if (got !== exp && (tol == 0 || $isunknown(got) || got > exp + tol || got + tol < exp)) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // count clk cycles while busy stands, bounded
  task automatic busy_span(output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 4000) begin @(negedge clk); n++; end
  endtask
  // timed op from the media side, ended by its bound, or by media_done when the limit is zero
  task automatic run_op(input op_kind_t k, input int lim);
    int n;
    busy_span(n);
    @(posedge clk);
    media_kind <= k;
    media_start <= 1'b1;
    @(posedge clk);
    media_start <= 1'b0;
    // a zero limit means the bound is out of reach: the media ends it
    if (lim == 0) begin
      repeat (20) @(negedge clk);
      chk(32'(op_kind), 32'(k));
      @(posedge clk);
      media_done <= 1'b1;
      @(posedge clk);
      media_done <= 1'b0;
    end
    busy_span(n);
    chk(32'(n), 32'(lim), 3);
  endtask
  // link write that must launch an op, then the media ends it
  task automatic link_op(input logic [8:0] idx, input logic [7:0] val, input op_kind_t k);
    host.send(LK_WRITE, idx, val);
    @(negedge clk);
    chk(32'(op_kind), 32'(k));
    chk(32'(link_busy), 32'd1);
    @(posedge clk);
    media_done <= 1'b1;
    @(posedge clk);
    media_done <= 1'b0;
  endtask
  //==========================================================================
  task automatic t_init;
    int n;
    busy_span(n);
    chk(32'(n), 32'd60, 3);
    chk(32'(cache_enable), 32'd0);
    chk(32'(maint_enable), 32'd0);
    chk(32'(link_fast), 32'd0);
    $display("test init done");
  endtask
  task automatic t_writes;
    host.send(LK_WRITE, 9'd33, 8'h01);
    host.send(LK_WRITE, 9'd163, 8'h01);
    host.send(LK_WRITE, 9'd185, 8'h01);
    host.send(LK_WRITE, 9'd501, 8'h00);
    host.send(LK_WRITE, 9'd160, 8'h00);
    host.send(LK_WRITE, 9'd31, 8'h55);
    repeat (4) @(negedge link_clk);
    chk(32'(cache_enable), 32'd1);
    chk(32'(maint_enable), 32'd1);
    chk(32'(link_fast), 32'd1);
    link_op(9'd164, 8'h01, OP_MAINT);
    link_op(9'd32, 8'h01, OP_FLUSH);
    link_op(9'd34, 8'h02, OP_PO_SHORT);
    link_op(9'd34, 8'h03, OP_PO_LONG);
    $display("test writes done");
  endtask
  task automatic t_cmd0;
    host.send(LK_WRITE, 9'd131, 8'h05);
    host.send(LK_WRITE, 9'd173, 8'h01);
    host.send(LK_WRITE, 9'd173, 8'h02);
    host.send(LK_WRITE, 9'd163, 8'h00);
    host.send(LK_CMD0, 9'd0, 8'h00);
    repeat (4) @(negedge link_clk);
    chk(32'(cache_enable), 32'd0);
    chk(32'(maint_enable), 32'd1);
    chk(32'(link_fast), 32'd0);
    $display("test cmd0 done");
  endtask
  // pin reset mid-run: volatile bytes and power-cleared locks drop, init reruns
  task automatic t_hwreset;
    int n;
    host.send(LK_WRITE, 9'd33, 8'h01);
    @(posedge clk);
    hw_reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    hw_reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    busy_span(n);
    chk(32'(n), 32'd60, 3);
    chk(32'(cache_enable), 32'd0);
    chk(32'(maint_enable), 32'd1);
    host.send(LK_WRITE, 9'd173, 8'h03);
    host.send(LK_WRITE, 9'd173, 8'h04);
    $display("test hwreset done");
  endtask
  task automatic t_timers;
    run_op(OP_TRIM, 80);
    run_op(OP_TRIM_AL, 0);
    run_op(OP_STRIM1, 100);
    run_op(OP_STRIM2, 110);
    run_op(OP_PART_SW, 70);
    $display("test timers done");
  endtask
  // one full image read; the link is slow, so it is read once at the end
  task automatic t_image;
    host.send(LK_READ, 9'd0, 8'h00);
    chk(32'(host.last_pos), 32'd511);
    chk(32'(host.img[501]), 32'h3F);
    chk(32'(host.img[500]), 32'h3F);
    chk(32'(host.img[502]), 32'h01);
    chk(32'(host.img[167]), 32'h1F);
    chk(32'(host.img[166]), 32'h05);
    chk(32'(host.img[160]), 32'h07);
    chk(32'(host.img[31]), 32'h00);
    chk(32'(host.img[510]), 32'h00);
    chk(32'(host.img[33]), 32'h00);
    chk(32'(host.img[131]), 32'h05);
    chk(32'(host.img[173]), 32'h03);
    chk(32'(host.img[163]), 32'h01);
    chk(32'(host.img[164]), 32'h00);
    chk(32'(host.img[32]), 32'h00);
    $display("test image done");
  endtask
  //==========================================================================
  // main sequence and watchdog sized for one slow image read plus writes
  initial begin
    repeat (3) @(posedge link_clk);
    reset <= 1'b0;
    t_init();
    t_writes();
    t_cmd0();
    t_hwreset();
    t_timers();
    t_image();
    finish_test();
  end
  initial begin
    #300_000;
    fail_count++;
    finish_test();
  end
endmodule // ext_config_bank_bench
`default_nettype wire

// ==== dv/link_host_model.sv ====
// host-side model of the link: offers commands and gathers read streams
`timescale 1ns/100ps
`default_nettype none
module link_host_model (
  input  wire logic                 link_clk,   // bus clock
  output ext_config_pkg::link_req_t cmd,        // command word
  output logic                      cmd_valid,  // command offered
  input  wire logic                 cmd_ready,  // command taken
  input  wire logic                 rd_valid,   // byte strobe
  input  wire logic                 rd_last,    // last byte flag
  input  wire logic [7:0]           rd_data     // read byte
);
  import ext_config_pkg::*;
  logic [7:0] img [512];  // last bank image gathered
  int last_pos = -1;      // index of the byte flagged last
  //==========================================================================
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // all sampling on the rising bus edge modes change only here
  task automatic send(input link_op_t op, input logic [8:0] idx, input logic [7:0] val);
    int n;
    @(posedge link_clk);
    cmd <= '{op, idx, val};
    cmd_valid <= 1'b1;
    @(posedge link_clk);
    while (!cmd_ready) @(posedge link_clk);
    cmd_valid <= 1'b0;
    cmd <= '{LK_WRITE, ~idx, ~val};  // a released word must not keep the old value
    if (op == LK_READ) begin
      // bytes land in arrival order, so order faults show as wrong bytes
      for (int i = 0; i < 512; i++) begin
        n = 0;
        do begin @(posedge link_clk); n++; end while (!rd_valid && n < 40);
        img[i] = rd_data;
        if (rd_last) last_pos = i;
      end
    end
    n = 0;
    do begin @(posedge link_clk); n++; end while (!cmd_ready && n < 40);
  endtask
endmodule // link_host_model
`default_nettype wire

// ==== shared/ext_config_pkg.sv ====
// package: byte indices, field classes, defaults and timing of the config bank
package ext_config_pkg;
  //==========================================================================
  // geometry and indices
  localparam int unsigned BANK_BYTES = 512;
  localparam int unsigned MODE_BYTES = 192;
  localparam int unsigned PROP_BYTES = BANK_BYTES - MODE_BYTES;
  localparam logic [8:0] IDX_FLUSH     = 9'h020;
  localparam logic [8:0] IDX_CACHE     = 9'h021;
  localparam logic [8:0] IDX_PWROFF    = 9'h022;
  localparam logic [8:0] IDX_WAKE      = 9'h083;
  localparam logic [8:0] IDX_PART_DONE = 9'h09B;
  localparam logic [8:0] IDX_ENH_LIM   = 9'h09D;
  localparam logic [8:0] IDX_MAINT_EN  = 9'h0A3;
  localparam logic [8:0] IDX_MAINT_GO  = 9'h0A4;
  localparam logic [8:0] IDX_PART_CFG  = 9'h0B3;
  localparam logic [8:0] IDX_FAST      = 9'h0B9;
  localparam logic [8:0] IDX_SEC_CNT   = 9'h0D4;
  localparam logic [8:0] IDX_GRP_WR    = 9'h1F4;
  localparam logic [8:0] IDX_GRP_RD    = 9'h1F5;
  localparam logic [8:0] IDX_LAST      = 9'h1FF;
  localparam logic [7:0] GROUP_LIMIT   = 8'h3F;
  localparam logic [7:0] PO_SHORT      = 8'h02;
  localparam logic [7:0] PO_LONG       = 8'h03;
  //==========================================================================
  // timing
  localparam longint unsigned CLK_MHZ = 250;
  localparam longint unsigned MS_CYC = 1000 * CLK_MHZ;
  localparam longint unsigned S_CYC = 1000000 * CLK_MHZ;
  localparam longint unsigned T_PART_SW_US = 100;
  localparam longint unsigned T_STRIM1_S = 5;
  localparam longint unsigned T_STRIM2_S = 3;
  localparam longint unsigned T_PO_SHORT_MS = 100;
  localparam longint unsigned T_PO_LONG_MS = 600;
  localparam longint unsigned T_TRIM_MS = 600;
  localparam longint unsigned T_TRIM_AL_MS = 300;
  localparam longint unsigned T_INIT_S = 1;
  localparam longint unsigned T_INIT_AP_S = 3;
  localparam logic [31:0] PART_CYC_DEF = 32'(T_PART_SW_US * CLK_MHZ);
  localparam logic [31:0] STRIM1_CYC_DEF = 32'(T_STRIM1_S * S_CYC);
  localparam logic [31:0] STRIM2_CYC_DEF = 32'(T_STRIM2_S * S_CYC);
  localparam logic [31:0] PO_SHORT_CYC_DEF = 32'(T_PO_SHORT_MS * MS_CYC);
  localparam logic [31:0] PO_LONG_CYC_DEF = 32'(T_PO_LONG_MS * MS_CYC);
  localparam logic [31:0] TRIM_CYC_DEF = 32'(T_TRIM_MS * MS_CYC);
  localparam logic [31:0] TRIM_AL_CYC_DEF = 32'(T_TRIM_AL_MS * MS_CYC);
  localparam logic [31:0] INIT_CYC_DEF = 32'(T_INIT_S * S_CYC);
  localparam logic [31:0] INIT_AP_CYC_DEF = 32'(T_INIT_AP_S * S_CYC);
  //==========================================================================
  // types
  typedef enum logic [2:0] {CL_RSVD, CL_RO, CL_E, CL_EP, CL_CP, CL_OTP, CL_OTP_WO, CL_WO_EP} field_class_t;
  typedef enum logic [1:0] {LK_WRITE, LK_READ, LK_CMD0} link_op_t;
  typedef enum logic [3:0] {OP_NONE, OP_INIT, OP_INIT_AP, OP_FLUSH, OP_MAINT, OP_PART_SW,
                            OP_PO_SHORT, OP_PO_LONG, OP_TRIM, OP_TRIM_AL, OP_STRIM1, OP_STRIM2} op_kind_t;
  typedef struct packed {
    link_op_t   op;
    logic [8:0] idx;
    logic [7:0] val;
  } link_req_t;
  //==========================================================================
  // per-byte tables
  function automatic field_class_t mode_class(input logic [8:0] i);
    case (i) inside
      9'h0BF, 9'h0BB, 9'h0B9, 9'h0B3, 9'h0AF, 9'h0AB, 9'h0A1, 9'h03B,
      [9'h038:9'h039], [9'h025:9'h033], [9'h021:9'h022]: return CL_EP;
      9'h0B7, 9'h0A5, 9'h0A4, 9'h084, 9'h020: return CL_WO_EP;
      9'h0B1, 9'h083: return CL_E;
      9'h0B2, 9'h0AD: return CL_CP;
      9'h0A9, 9'h0A7, 9'h0A3, 9'h0A2, 9'h09C, 9'h09B, [9'h088:9'h09A], 9'h086, 9'h03E,
      [9'h034:9'h035]: return CL_OTP;
      9'h0BD, 9'h0B5, 9'h0AE, 9'h0A8, 9'h0A6, 9'h0A0, [9'h09D:9'h09F], 9'h082, [9'h040:9'h07F],
      9'h03F, 9'h03C, 9'h03A, [9'h036:9'h037], [9'h023:9'h024]: return CL_RO;
      default: return CL_RSVD;
    endcase
  endfunction
  function automatic logic [7:0] mode_default(input logic [8:0] i);
    case (i)
      9'h0A7: return 8'h1F;
      9'h0A6: return 8'h05;
      9'h0A8, 9'h082: return 8'h01;
      9'h0A0: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [MODE_BYTES-1:0][7:0] mode_reset_all();
    for (int k = 0; k < MODE_BYTES; k++) mode_reset_all[k] = mode_default(9'(k));
  endfunction
  localparam logic [MODE_BYTES-1:0][7:0] MODE_RESET = mode_reset_all();
  function automatic logic [7:0] prop_byte(input logic [8:0] i);
    case (i)
      9'h1F8, 9'h1F7, 9'h1F6, 9'h1F3, 9'h0FB, 9'h0E0, 9'h0DF, 9'h0DE, 9'h0C7: return 8'h01;
      IDX_GRP_RD, IDX_GRP_WR: return GROUP_LIMIT;
      9'h1F2: return 8'h04;
      9'h1F0: return 8'h05;
      9'h1EF, 9'h0E4, 9'h0E1, 9'h0DC, 9'h0DB, 9'h0C4: return 8'h07;
      9'h1EE: return 8'h03;
      9'h0F8: return 8'h0A;
      9'h0F1: return 8'h1E;
      9'h0E8, 9'h0C6, 9'h0C2: return 8'h02;
      9'h0E7: return 8'h55;
      9'h0E6: return 8'h1B;
      9'h0E5, 9'h0D9: return 8'h11;
      9'h0E2: return 8'h10;
      9'h0DD: return 8'h50;
      default: return 8'h00;
    endcase
  endfunction
endpackage

// ==== verilog/ext_config_bank.sv ====
// extended configuration bank: link command port, byte storage, operation timers
`timescale 1ns/100ps
`default_nettype none
//============================================================================
//============================================================================
module ext_config_bank #(
  parameter logic [31:0] PART_CYC     = ext_config_pkg::PART_CYC_DEF,     // switch bound
  parameter logic [31:0] STRIM1_CYC   = ext_config_pkg::STRIM1_CYC_DEF,   // secure trim 1
  parameter logic [31:0] STRIM2_CYC   = ext_config_pkg::STRIM2_CYC_DEF,   // secure trim 2
  parameter logic [31:0] PO_SHORT_CYC = ext_config_pkg::PO_SHORT_CYC_DEF, // short notice
  parameter logic [31:0] PO_LONG_CYC  = ext_config_pkg::PO_LONG_CYC_DEF,  // long notice
  parameter logic [31:0] TRIM_CYC     = ext_config_pkg::TRIM_CYC_DEF,     // trim
  parameter logic [31:0] TRIM_AL_CYC  = ext_config_pkg::TRIM_AL_CYC_DEF,  // aligned trim
  parameter logic [31:0] INIT_CYC     = ext_config_pkg::INIT_CYC_DEF,     // init
  parameter logic [31:0] INIT_AP_CYC  = ext_config_pkg::INIT_AP_CYC_DEF,  // init after setup
  parameter logic [31:0] SEC_COUNT    = 32'h01D1_F000,                    // capacity in sectors
  parameter logic [23:0] ENH_LIMIT    = 24'h00_00BA,                      // enhanced size limit
  parameter logic [7:0]  EXT_REV      = 8'h06                             // layout revision
) (
  input  wire logic                      clk,           // core clock
  input  wire logic                      reset,         // async, power-on
  input  wire logic                      link_clk,      // bus clock from host
  input  wire logic                      cmd_valid,     // link command offered
  input  wire ext_config_pkg::link_req_t cmd,           // link command word
  output logic                           cmd_ready,     // link command taken
  output logic                           rd_valid,      // read byte strobe
  output logic                           rd_last,       // last byte of read
  output logic [7:0]                     rd_data,       // read byte
  output logic                           link_fast,     // fast timing in force
  output logic                           link_busy,     // operation running
  input  wire logic                      hw_reset_pin,  // hardware reset pin
  input  wire logic                      media_start,   // media asks for a timed op
  input  wire ext_config_pkg::op_kind_t  media_kind,    // kind of that op
  input  wire logic                      media_done,    // media finished current op
  output ext_config_pkg::op_kind_t       op_kind,       // op in progress
  output logic                           busy,          // op in progress
  output logic                           cache_enable,  // write cache on
  output logic                           maint_enable   // maintenance handshake on
);
  import ext_config_pkg::*;

  typedef struct packed {
    logic [MODE_BYTES-1:0][7:0] mode;
    logic [MODE_BYTES-1:0]      lock;
    logic                       req_s1;
    logic                       req_s2;
    logic                       req_seen;
    logic                       hwr_s1;
    logic                       hwr_s2;
    logic                       hwr_s3;
    logic                       ack_t;
    logic [7:0]                 rsp;
    op_kind_t                   op;
    logic [31:0]                cnt;
    logic [31:0]                lim;
  } core_state_t;

  typedef enum logic [1:0] {L_IDLE, L_WAIT} link_st_t;

  typedef struct packed {
    link_st_t   st;
    link_req_t  req;
    logic       req_t;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_seen;
    logic       busy_s1;
    logic       busy_s2;
    logic       fast_s1;
    logic       fast_s2;
    logic       rd_valid;
    logic       rd_last;
    logic [7:0] rd_data;
  } link_state_t;

  core_state_t st_r;
  core_state_t st_nxt;
  link_state_t lk_r;
  link_state_t lk_nxt;
  logic        req_new;
  link_req_t   cur;
  logic        wr_ok;
  op_kind_t    start;

  //==========================================================================
  // helpers
  function automatic logic [31:0] lim_of(input op_kind_t k);
    case (k)
      OP_INIT:     return INIT_CYC;
      OP_INIT_AP:  return INIT_AP_CYC;
      OP_PART_SW:  return PART_CYC;
      OP_STRIM1:   return STRIM1_CYC;
      OP_STRIM2:   return STRIM2_CYC;
      OP_PO_SHORT: return PO_SHORT_CYC;
      OP_PO_LONG:  return PO_LONG_CYC;
      OP_TRIM:     return TRIM_CYC;
      OP_TRIM_AL:  return TRIM_AL_CYC;
      default:     return 32'h0000_0000;
    endcase
  endfunction

  // read view of one byte; hidden and reserved bytes give zero
  function automatic logic [7:0] rd_byte(input logic [8:0] i);
    if (i >= 9'(MODE_BYTES)) begin
      if (i == 9'(MODE_BYTES)) return EXT_REV;
      if (i[8:2] == IDX_SEC_CNT[8:2]) return SEC_COUNT[{i[1:0], 3'b000} +: 8];
      return prop_byte(i);
    end
    case (mode_class(i))
      CL_RSVD, CL_WO_EP, CL_OTP_WO: return 8'h00;
      default: begin
        if (i >= IDX_ENH_LIM && i <= IDX_ENH_LIM + 9'h002) return ENH_LIMIT[{i[1:0] - 2'h1, 3'b000} +: 8];
        return st_r.mode[i[7:0]];
      end
    endcase
  endfunction

  assign req_new = st_r.req_s2 != st_r.req_seen;
  assign cur     = lk_r.req;

  //==========================================================================
  // core domain next state
  always_comb begin
    field_class_t c;
    c = CL_RSVD;
    st_nxt = st_r;
    wr_ok = 1'b0;
    start = OP_NONE;
    st_nxt.req_s1 = lk_r.req_t;
    st_nxt.req_s2 = st_r.req_s1;
    st_nxt.hwr_s1 = hw_reset_pin;
    st_nxt.hwr_s2 = st_r.hwr_s1;
    st_nxt.hwr_s3 = st_r.hwr_s2;
    // timer forces an end at the bound even if the media is late
    if (st_r.op != OP_NONE) begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      if (media_done || (st_r.lim != 32'h0000_0000 && st_r.cnt == st_r.lim - 32'h0000_0001)) begin
        st_nxt.op = OP_NONE;
        st_nxt.cnt = 32'h0000_0000;
      end
    end
    if (req_new) begin
      st_nxt.req_seen = st_r.req_s2;
      st_nxt.ack_t = ~st_r.ack_t;
      c = mode_class(cur.idx);
      case (cur.op)
        LK_READ: st_nxt.rsp = rd_byte(cur.idx);
        LK_WRITE: begin
          if (cur.idx < 9'(MODE_BYTES)) begin
            case (c)
              CL_E, CL_EP, CL_WO_EP: wr_ok = 1'b1;
              CL_CP, CL_OTP, CL_OTP_WO: wr_ok = !st_r.lock[cur.idx[7:0]];
              default: wr_ok = 1'b0;
            endcase
          end
          if (wr_ok) begin
            st_nxt.mode[cur.idx[7:0]] = cur.val;
            if (c != CL_E && c != CL_EP && c != CL_WO_EP) st_nxt.lock[cur.idx[7:0]] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // writes with side effects start an op only when none runs
    if (wr_ok && st_r.op == OP_NONE) begin
      if (cur.idx == IDX_FLUSH) start = OP_FLUSH;
      else if (cur.idx == IDX_MAINT_GO) start = OP_MAINT;
      else if (cur.idx == IDX_PART_CFG) start = OP_PART_SW;
      else if (cur.idx == IDX_PWROFF && cur.val == PO_SHORT) start = OP_PO_SHORT;
      else if (cur.idx == IDX_PWROFF && cur.val == PO_LONG) start = OP_PO_LONG;
    end else if (media_start && st_r.op == OP_NONE) begin
      start = media_kind;
    end
    // release of the reset pin reruns init; setup done selects the long bound
    if (st_r.hwr_s3 && !st_r.hwr_s2) begin
      start = st_r.mode[IDX_PART_DONE[7:0]][0] ? OP_INIT_AP : OP_INIT;
    end
    if (start != OP_NONE) begin
      st_nxt.op = start;
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.lim = lim_of(start);
    end
    // resets of the field classes, applied after any write of this cycle
    for (int k = 0; k < MODE_BYTES; k++) begin
      c = mode_class(9'(k));
      if (((req_new && cur.op == LK_CMD0) || st_r.hwr_s2) && (c == CL_EP || c == CL_WO_EP)) begin
        st_nxt.mode[k] = MODE_RESET[k];
      end
      if (st_r.hwr_s2 && c == CL_CP) begin
        st_nxt.mode[k] = MODE_RESET[k];
        st_nxt.lock[k] = 1'b0;
      end
    end
  end

  // core domain registers; persistent bytes reload defaults only at power-on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.mode <= MODE_RESET;
      st_r.op <= OP_INIT;
      st_r.lim <= INIT_CYC;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign op_kind      = st_r.op;
  assign busy         = st_r.op != OP_NONE;
  assign cache_enable = st_r.mode[IDX_CACHE[7:0]][0];
  assign maint_enable = st_r.mode[IDX_MAINT_EN[7:0]][0];

  //==========================================================================
  // link domain next state; one handshake per byte keeps words stable
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.ack_s1 = st_r.ack_t;
    lk_nxt.ack_s2 = lk_r.ack_s1;
    lk_nxt.busy_s1 = st_r.op != OP_NONE;
    lk_nxt.busy_s2 = lk_r.busy_s1;
    lk_nxt.fast_s1 = st_r.mode[IDX_FAST[7:0]] != 8'h00;
    lk_nxt.fast_s2 = lk_r.fast_s1;
    lk_nxt.rd_valid = 1'b0;
    lk_nxt.rd_last = 1'b0;
    case (lk_r.st)
      L_IDLE: begin
        if (cmd_valid) begin
          lk_nxt.req = cmd;
          if (cmd.op == LK_READ) lk_nxt.req.idx = 9'h000;
          lk_nxt.req_t = ~lk_r.req_t;
          lk_nxt.st = L_WAIT;
        end
      end
      L_WAIT: begin
        if (lk_r.ack_s2 != lk_r.ack_seen) begin
          lk_nxt.ack_seen = lk_r.ack_s2;
          if (lk_r.req.op == LK_READ) begin
            lk_nxt.rd_valid = 1'b1;
            lk_nxt.rd_data = st_r.rsp;
            lk_nxt.rd_last = lk_r.req.idx == IDX_LAST;
            if (lk_r.req.idx == IDX_LAST) begin
              lk_nxt.st = L_IDLE;
            end else begin
              lk_nxt.req.idx = lk_r.req.idx + 9'h001;
              lk_nxt.req_t = ~lk_r.req_t;
            end
          end else begin
            lk_nxt.st = L_IDLE;
          end
        end
      end
      default: lk_nxt.st = L_IDLE;
    endcase
  end

  // link registers take inputs on the rising bus clock edge
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  assign cmd_ready = lk_r.st == L_IDLE;
  assign rd_valid  = lk_r.rd_valid;
  assign rd_last   = lk_r.rd_last;
  assign rd_data   = lk_r.rd_data;
  assign link_fast = lk_r.fast_s2;
  assign link_busy = lk_r.busy_s2;

  //==========================================================================
  // checks
  sequence s_write_to(logic [8:0] i);
    req_new && cur.op == LK_WRITE && cur.idx == i;
  endsequence

  sequence s_cmd0;
    req_new && cur.op == LK_CMD0 && !st_r.hwr_s2;
  endsequence

  property p_prop_ro;
    @(posedge clk) disable iff (reset)
    req_new && cur.op == LK_WRITE && cur.idx >= 9'(MODE_BYTES) && !st_r.hwr_s2 |=> $stable(st_r.mode);
  endproperty
  a_prop_ro: assert property (p_prop_ro) else $error("properties write changed bank");

  property p_e_write;
    @(posedge clk) disable iff (reset)
    s_write_to(IDX_WAKE) |=> st_r.mode[IDX_WAKE[7:0]] == $past(cur.val);
  endproperty
  a_e_write: assert property (p_e_write) else $error("persistent byte did not take write");

  property p_e_keep;
    @(posedge clk) disable iff (reset)
    (st_r.hwr_s2 || (req_new && cur.op == LK_CMD0)) && !(req_new && cur.op == LK_WRITE)
      |=> $stable(st_r.mode[IDX_WAKE[7:0]]);
  endproperty
  a_e_keep: assert property (p_e_keep) else $error("persistent byte lost on reset");

  property p_cmd0_clear;
    @(posedge clk) disable iff (reset)
    s_cmd0 |=> st_r.mode[IDX_CACHE[7:0]] == 8'h00 && st_r.mode[IDX_FAST[7:0]] == 8'h00 && $stable(st_r.lock);
  endproperty
  a_cmd0_clear: assert property (p_cmd0_clear) else $error("cmd0 clear wrong");

  property p_otp_once;
    @(posedge clk) disable iff (reset)
    req_new && cur.op == LK_WRITE && cur.idx < 9'(MODE_BYTES) && st_r.lock[cur.idx[7:0]] && !st_r.hwr_s2
      |=> $stable(st_r.mode);
  endproperty
  a_otp_once: assert property (p_otp_once) else $error("locked byte rewritten");

  property p_hidden;
    @(posedge clk) disable iff (reset)
    req_new && cur.op == LK_READ && cur.idx < 9'(MODE_BYTES)
      && (mode_class(cur.idx) == CL_WO_EP || mode_class(cur.idx) == CL_RSVD) |=> st_r.rsp == 8'h00;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden byte read nonzero");

  property p_group;
    @(posedge clk) disable iff (reset)
    req_new && cur.op == LK_READ && (cur.idx == IDX_GRP_RD || cur.idx == IDX_GRP_WR) |=> st_r.rsp == GROUP_LIMIT;
  endproperty
  a_group: assert property (p_group) else $error("grouping limit wrong");

  property p_go;
    @(posedge clk) disable iff (reset)
    (s_write_to(IDX_MAINT_GO) or s_write_to(IDX_FLUSH)) and (st_r.op == OP_NONE && !st_r.hwr_s3)
      |=> st_r.op == OP_MAINT || st_r.op == OP_FLUSH;
  endproperty
  a_go: assert property (p_go) else $error("write did not start op");

  property p_bound;
    @(posedge clk) disable iff (reset)
    st_r.op != OP_NONE && st_r.lim != 32'h0000_0000 |-> st_r.cnt < st_r.lim;
  endproperty
  a_bound: assert property (p_bound) else $error("op ran past bound");

  property p_part_lim;
    @(posedge clk) disable iff (reset)
    st_r.op == OP_PART_SW |-> st_r.lim == PART_CYC;
  endproperty
  a_part_lim: assert property (p_part_lim) else $error("switch bound wrong");

  property p_read_next;
    @(posedge link_clk) disable iff (reset)
    rd_valid && !rd_last |-> ##[1:16] rd_valid;
  endproperty
  a_read_next: assert property (p_read_next) else $error("read stream stalled");
endmodule // ext_config_bank
`default_nettype wire
